// file: src/front_panel_pkg.sv
package front_panel_pkg;

    // =========================================================
    // Timing
    localparam int unsigned CLOCK_HZ        = 50_000_000;
    localparam int unsigned CYCLES_PER_MS   = CLOCK_HZ / 1000;
    localparam int unsigned DEBOUNCE_MS     = 10;
    localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * CYCLES_PER_MS;
    localparam int unsigned PGOOD_MS        = 100;
    localparam int unsigned PGOOD_CYCLES    = PGOOD_MS * CYCLES_PER_MS;
    localparam int unsigned RESET_MS        = 10;
    localparam int unsigned RESET_CYCLES    = RESET_MS * CYCLES_PER_MS;
    localparam int unsigned FAILSAFE_MS     = 4000;
    localparam int unsigned FAILSAFE_CYCLES = FAILSAFE_MS * CYCLES_PER_MS;
    localparam int unsigned BLINK_HZ        = 1;
    localparam int unsigned BLINK_HALF      = CLOCK_HZ / (2 * BLINK_HZ);

    // =========================================================
    // Widths and field positions
    localparam int unsigned TIMER_W  = 28;
    localparam int unsigned DEB_W    = 20;
    localparam int unsigned SYNC_W   = 4;
    localparam int unsigned SY_WAKE  = 0;
    localparam int unsigned SY_OFF   = 1;
    localparam int unsigned SY_S1    = 2;
    localparam int unsigned SY_OS    = 3;

    // =========================================================
    // State
    typedef enum logic [1:0] {
        SEQ_OFF,
        SEQ_SUPPLY,
        SEQ_PGOOD,
        SEQ_ON
    } seq_state_type;

    typedef struct packed {
        logic              sync1;
        logic              sync2;
        logic              level;
        logic              press;
        logic [DEB_W-1:0]  count;
    } deb_type;

    typedef struct packed {
        seq_state_type       state;
        logic [TIMER_W-1:0]  timer;
        logic [TIMER_W-1:0]  failsafe;
        logic                failsafe_run;
        logic [TIMER_W-1:0]  blink_cnt;
        logic                blink;
        logic [SYNC_W-1:0]   sync1;
        logic [SYNC_W-1:0]   sync2;
        logic                prev_wake;
        logic                supply;
        logic                pgood;
        logic                rst_n;
        logic                pb_req;
        logic                smi;
        logic                sci;
        logic                pb_status;
        logic                rst_req;
        logic                id_on;
        logic                id_lamp_n;
        logic                pwr_lamp_n;
    } ctl_type;

endpackage : front_panel_pkg

// file: src/button_debounce.sv
module button_debounce #(
    parameter int unsigned STABLE_CYCLES = front_panel_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic i_clock,    // System clock
    input  wire logic i_sys_rst,  // Synchronous reset
    input  wire logic i_pin_n,    // Raw button, low when pressed
    output logic      o_level,    // Debounced, high while held
    output logic      o_press     // One-cycle pulse per press
);

    localparam int unsigned DW = front_panel_pkg::DEB_W;

    front_panel_pkg::deb_type r;
    front_panel_pkg::deb_type n;

    // =========================================================
    // Synchronise, then accept a new level only once stable
    always_comb begin
        n       = r;
        n.press = 1'b0;
        n.sync1 = i_pin_n;
        n.sync2 = r.sync1;
        if (~r.sync2 == r.level) begin
            n.count = '0;
        end else if (r.count == DW'(STABLE_CYCLES - 1)) begin
            n.level = ~r.sync2;
            n.press = ~r.sync2;
            n.count = '0;
        end else begin
            n.count = r.count + 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            r       <= '0;
            // Idle pin is high; avoids a false press after reset
            r.sync1 <= 1'b1;
            r.sync2 <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign o_level = r.level;
    assign o_press = r.press;

endmodule : button_debounce

// file: src/front_panel_power_control.sv
// Function
// - Power button or chipset wake transition starts the power-up sequence.
// - Controller drives power-good and reset; platform then goes on.
// - While on, power press is only forwarded to the chipset; never switches supply.
// - Without an OS the press raises SMI and sets a status flag.
// - Chipset off state deasserts the supply-on request.
// - Unserviced power-off without an OS: fail-safe turns supply off after four seconds.
// - With an ACPI OS running the press raises an SCI request.
// - Reset press while on goes to the chipset as a request, unaffected by firmware.
// - Each identify press inverts the identify lamp.
// - Identify lamp holds until another press or an identify command.
// - Power lamp lit when DC power present, pattern from DC and sleep state.
// - Dark when off or S5, solid when on or S0, ~1 Hz in S1 while an ACPI OS runs.
module front_panel_power_control #(
    parameter int unsigned PGOOD_CYCLES    = front_panel_pkg::PGOOD_CYCLES,
    parameter int unsigned RESET_CYCLES    = front_panel_pkg::RESET_CYCLES,
    parameter int unsigned FAILSAFE_CYCLES = front_panel_pkg::FAILSAFE_CYCLES,
    parameter int unsigned BLINK_HALF      = front_panel_pkg::BLINK_HALF,
    parameter int unsigned DEBOUNCE_CYCLES = front_panel_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic i_clock,                 // 50 MHz standby clock
    input  wire logic i_sys_rst,               // Synchronous reset
    input  wire logic i_front_power_button_n,  // Power button pin
    input  wire logic i_front_reset_button_n,  // Reset button pin
    input  wire logic i_front_identify_button_n, // Identify button pin
    input  wire logic i_wake_event,            // Chipset wake level
    input  wire logic i_chipset_off,           // Chipset reports off/S5
    input  wire logic i_chipset_s1,            // Chipset reports S1
    input  wire logic i_acpi_os,               // ACPI OS running
    input  wire logic i_status_clear,          // Firmware clears status
    input  wire logic i_identify_cmd_valid,    // Identify command strobe
    input  wire logic i_identify_cmd_on,       // Commanded lamp state
    output logic      o_supply_on_request,     // Supply enable
    output logic      o_power_good,            // Power good to platform
    output logic      o_platform_reset_n,      // Platform reset, low
    output logic      o_power_button_request,  // Request to chipset
    output logic      o_smi_request,           // SMI pulse
    output logic      o_sci_request,           // SCI pulse
    output logic      o_power_button_status,   // Sticky status flag
    output logic      o_reset_request,         // Reset request pulse
    output logic      o_identify_lamp_n,       // Identify lamp, low on
    output logic      o_power_lamp_n           // Power lamp, low on
);

    localparam int unsigned TW = front_panel_pkg::TIMER_W;

    front_panel_pkg::ctl_type r;
    front_panel_pkg::ctl_type n;
    logic pwr_press;
    logic rst_press;
    logic id_press;
    logic wake_edge;
    logic chip_off;
    logic chip_s1;
    logic os_on;
    logic dc_on;
    logic lamp_lit;

    // =========================================================
    // Button conditioning
    button_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_pwr_btn (
        .i_clock (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_pin_n (i_front_power_button_n),
        .o_level (),
        .o_press (pwr_press)
    );

    button_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_rst_btn (
        .i_clock (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_pin_n (i_front_reset_button_n),
        .o_level (),
        .o_press (rst_press)
    );

    button_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_id_btn (
        .i_clock (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_pin_n (i_front_identify_button_n),
        .o_level (),
        .o_press (id_press)
    );

    // =========================================================
    // Chipset level views, read only after the second flop
    assign chip_off  = r.sync2[front_panel_pkg::SY_OFF];
    assign chip_s1   = r.sync2[front_panel_pkg::SY_S1];
    assign os_on     = r.sync2[front_panel_pkg::SY_OS];
    assign wake_edge = r.sync2[front_panel_pkg::SY_WAKE] ^ r.prev_wake;
    assign dc_on     = (r.state == front_panel_pkg::SEQ_ON);
    assign lamp_lit  = dc_on && !(os_on && chip_off)
                       && !(os_on && chip_s1 && !r.blink);

    // =========================================================
    // Next state
    always_comb begin
        n           = r;
        n.pb_req    = 1'b0;
        n.smi       = 1'b0;
        n.sci       = 1'b0;
        n.rst_req   = 1'b0;
        n.sync1     = {i_acpi_os, i_chipset_s1, i_chipset_off,
                       i_wake_event};
        n.sync2     = r.sync1;
        n.prev_wake = r.sync2[front_panel_pkg::SY_WAKE];

        // Free-running blink base, equal on and off halves
        if (r.blink_cnt == TW'(BLINK_HALF - 1)) begin
            n.blink_cnt = '0;
            n.blink     = ~r.blink;
        end else begin
            n.blink_cnt = r.blink_cnt + 1'b1;
        end

        unique case (r.state)
            front_panel_pkg::SEQ_OFF: begin
                n.supply       = 1'b0;
                n.pgood        = 1'b0;
                n.rst_n        = 1'b0;
                n.failsafe_run = 1'b0;
                if (pwr_press || wake_edge) begin
                    n.state  = front_panel_pkg::SEQ_SUPPLY;
                    n.supply = 1'b1;
                    n.timer  = '0;
                end
            end
            front_panel_pkg::SEQ_SUPPLY: begin
                // Give the rails time to settle before power good
                if (r.timer == TW'(PGOOD_CYCLES - 1)) begin
                    n.state = front_panel_pkg::SEQ_PGOOD;
                    n.pgood = 1'b1;
                    n.timer = '0;
                end else begin
                    n.timer = r.timer + 1'b1;
                end
            end
            front_panel_pkg::SEQ_PGOOD: begin
                if (r.timer == TW'(RESET_CYCLES - 1)) begin
                    n.state = front_panel_pkg::SEQ_ON;
                    n.rst_n = 1'b1;
                    n.timer = '0;
                end else begin
                    n.timer = r.timer + 1'b1;
                end
            end
            front_panel_pkg::SEQ_ON: begin
                // Press only becomes a request; supply untouched
                if (pwr_press) begin
                    n.pb_req = 1'b1;
                    if (os_on) begin
                        n.sci = 1'b1;
                    end else begin
                        n.smi          = 1'b1;
                        n.failsafe_run = 1'b1;
                        n.failsafe     = '0;
                    end
                end else if (r.failsafe_run) begin
                    n.failsafe = r.failsafe + 1'b1;
                end
                if (rst_press) begin
                    n.rst_req = 1'b1;
                end
                // A fresh press restarts the fail-safe instead of firing it
                if (chip_off || (r.failsafe_run && !pwr_press &&
                                 r.failsafe == TW'(FAILSAFE_CYCLES - 1))) begin
                    n.state        = front_panel_pkg::SEQ_OFF;
                    n.supply       = 1'b0;
                    n.pgood        = 1'b0;
                    n.rst_n        = 1'b0;
                    n.failsafe_run = 1'b0;
                end
            end
        endcase

        // Set after clear so a press in the clear cycle is kept
        if (i_status_clear) begin
            n.pb_status = 1'b0;
        end
        if (r.state == front_panel_pkg::SEQ_ON && pwr_press && !os_on) begin
            n.pb_status = 1'b1;
        end

        // A press beats a command arriving in the same cycle
        if (id_press) begin
            n.id_on = ~r.id_on;
        end else if (i_identify_cmd_valid) begin
            n.id_on = i_identify_cmd_on;
        end
        n.id_lamp_n  = ~n.id_on;
        n.pwr_lamp_n = ~lamp_lit;
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            r            <= '0;
            r.id_lamp_n  <= 1'b1;
            r.pwr_lamp_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign o_supply_on_request    = r.supply;
    assign o_power_good           = r.pgood;
    assign o_platform_reset_n     = r.rst_n;
    assign o_power_button_request = r.pb_req;
    assign o_smi_request          = r.smi;
    assign o_sci_request          = r.sci;
    assign o_power_button_status  = r.pb_status;
    assign o_reset_request        = r.rst_req;
    assign o_identify_lamp_n      = r.id_lamp_n;
    assign o_power_lamp_n         = r.pwr_lamp_n;

    // =========================================================
    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    property p_start;
        (r.state == front_panel_pkg::SEQ_OFF && (pwr_press || wake_edge))
            |=> o_supply_on_request && !o_power_good;
    endproperty
    a_start: assert property (p_start) else $error("no power-up");

    property p_pgood_order;
        $rose(o_power_good) |-> o_supply_on_request && !o_platform_reset_n;
    endproperty
    a_pgood_order: assert property (p_pgood_order)
        else $error("power good out of order");

    property p_no_direct;
        (dc_on && pwr_press && !chip_off) |=>
            o_supply_on_request && o_power_button_request;
    endproperty
    a_no_direct: assert property (p_no_direct)
        else $error("button switched supply");

    property p_smi;
        (dc_on && pwr_press && !os_on) |=> o_smi_request
            && !o_sci_request && o_power_button_status;
    endproperty
    a_smi: assert property (p_smi) else $error("no smi");

    property p_chip_off;
        (dc_on && chip_off) |=> !o_supply_on_request ##1
            !o_supply_on_request;
    endproperty
    a_chip_off: assert property (p_chip_off)
        else $error("supply kept on");

    property p_failsafe;
        (r.failsafe_run && dc_on && !pwr_press &&
         r.failsafe == TW'(FAILSAFE_CYCLES - 1)) |=> !o_supply_on_request;
    endproperty
    a_failsafe: assert property (p_failsafe)
        else $error("fail-safe missed");

    property p_sci;
        (dc_on && pwr_press && os_on) |=> o_sci_request && !o_smi_request;
    endproperty
    a_sci: assert property (p_sci) else $error("no sci");

    property p_reset_req;
        (dc_on && rst_press) |=> o_reset_request ##1 !o_reset_request;
    endproperty
    a_reset_req: assert property (p_reset_req)
        else $error("reset request wrong");

    property p_id_toggle;
        id_press |=> o_identify_lamp_n != $past(o_identify_lamp_n);
    endproperty
    a_id_toggle: assert property (p_id_toggle)
        else $error("identify did not toggle");

    property p_lamp_dark;
        !dc_on |=> o_power_lamp_n;
    endproperty
    a_lamp_dark: assert property (p_lamp_dark)
        else $error("power lamp lit while off");

    c_power_up: cover property ($rose(o_platform_reset_n));
    c_failsafe: cover property (r.failsafe_run ##1 !o_supply_on_request);
    c_blink:    cover property (dc_on && chip_s1 && os_on && $rose(r.blink));

endmodule : front_panel_power_control

// file: dv/chipset_model.sv
module chipset_model (
    input  wire logic i_clock,       // System clock
    input  wire logic i_rst,         // Bench reset, high
    input  wire logic i_supply_on,   // Supply enable from controller
    input  wire logic i_pb_request,  // Forwarded button press
    input  wire logic i_serve,       // Firmware services off requests
    input  wire logic i_slow,        // Firmware answers late
    input  wire logic i_wake_kick,   // Toggle the wake level
    input  wire logic i_os,          // ACPI OS present
    input  wire logic i_s1,          // Chipset sleeping in S1
    output logic      o_wake_event,  // Wake level
    output logic      o_chipset_off, // Chipset in off state
    output logic      o_chipset_s1,  // Chipset in S1
    output logic      o_acpi_os      // OS present
);
    timeunit 1ns;
    timeprecision 1ps;

    int   lag;
    logic pend;

    assign o_chipset_s1 = i_s1;
    assign o_acpi_os    = i_os;

    // =========================================================
    // Off request service; off level cleared once supply is gone
    // so a later power-up never meets a stale off state
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_wake_event  <= 1'b0;
            o_chipset_off <= 1'b0;
            pend          <= 1'b0;
            lag           <= 0;
        end else begin
            if (i_wake_kick)
                o_wake_event <= ~o_wake_event;
            if (!i_supply_on)
                o_chipset_off <= 1'b0;
            if (i_pb_request && i_serve) begin
                pend <= 1'b1;
                lag  <= i_slow ? 30 : 2;
            end else if (pend && lag > 0) begin
                lag <= lag - 1;
            end else if (pend) begin
                o_chipset_off <= 1'b1;
                pend          <= 1'b0;
            end
        end
    end
endmodule : chipset_model

// file: dv/front_panel_power_control_tb.sv
module front_panel_power_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, sys_rst, pwr_n, rbt_n, id_n, clr, cv, con;
    logic serve, slow, kick, os, s1;
    logic sup, pg, prst_n, pbr, smi, sci, sts, rrq, idl_n, pwl_n;
    logic wake, coff, cs1, aos;
    int   n_mismatch, cmp_count, n_pb, n_smi, n_sci, n_rr;

    front_panel_power_control #(.PGOOD_CYCLES(8), .RESET_CYCLES(8),
        .FAILSAFE_CYCLES(40), .BLINK_HALF(4), .DEBOUNCE_CYCLES(4)) dut (
        .i_clock(clock), .i_sys_rst(sys_rst),
        .i_front_power_button_n(pwr_n), .i_front_reset_button_n(rbt_n),
        .i_front_identify_button_n(id_n), .i_wake_event(wake),
        .i_chipset_off(coff), .i_chipset_s1(cs1), .i_acpi_os(aos),
        .i_status_clear(clr), .i_identify_cmd_valid(cv),
        .i_identify_cmd_on(con), .o_supply_on_request(sup),
        .o_power_good(pg), .o_platform_reset_n(prst_n),
        .o_power_button_request(pbr), .o_smi_request(smi),
        .o_sci_request(sci), .o_power_button_status(sts),
        .o_reset_request(rrq), .o_identify_lamp_n(idl_n),
        .o_power_lamp_n(pwl_n));

    chipset_model chip (.i_clock(clock), .i_rst(sys_rst), .i_supply_on(sup),
        .i_pb_request(pbr), .i_serve(serve), .i_slow(slow),
        .i_wake_kick(kick), .i_os(os), .i_s1(s1), .o_wake_event(wake),
        .o_chipset_off(coff), .o_chipset_s1(cs1), .o_acpi_os(aos));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Pulses are counted on the rising edge so tasks read settled totals
    always @(posedge clock) begin
        n_pb  <= n_pb + int'(pbr === 1'b1);
        n_smi <= n_smi + int'(smi === 1'b1);
        n_sci <= n_sci + int'(sci === 1'b1);
        n_rr  <= n_rr + int'(rrq === 1'b1);
    end

    // =========================================================
    // Helpers
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick

    task automatic press(input int which);
        case (which)
            0: pwr_n = 1'b0;
            1: rbt_n = 1'b0;
            default: id_n = 1'b0;
        endcase
        tick(8);
        {pwr_n, rbt_n, id_n} = 3'b111;
        tick(8);
    endtask : press

    task automatic wait_sup(input logic v, input int lim);
        int n;
        n = 0;
        while (sup !== v && n < lim) begin
            tick(1);
            n++;
        end
        if (sup !== v) begin
            check("supply wait", sup, v);
            finish_test();
        end
    endtask : wait_sup

    // =========================================================
    // Scenarios
    task automatic t_reset_state;
        check("reset outputs", {sup, pg, prst_n, sts}, 8'h0);
        check("reset lamps", {idl_n, pwl_n}, 8'h3);
        press(1);
        check("reset btn while off", n_rr, 0);
    endtask : t_reset_state

    task automatic t_identify;
        press(2);
        check("id lit by press", idl_n, 0);
        cv = 1'b1; con = 1'b1; tick(1); cv = 1'b0; tick(2);
        check("id cmd same state", idl_n, 0);
        press(2);
        check("id dark by press", idl_n, 1);
        cv = 1'b1; tick(1); cv = 1'b0; tick(2);
        check("id cmd on", idl_n, 0);
        cv = 1'b1; con = 1'b0; tick(1); cv = 1'b0; tick(2);
        check("id cmd off", idl_n, 1);
    endtask : t_identify

    task automatic power_up(input logic by_wake);
        int n;
        // Pin stays low until supply rises, so the delay counts below
        // start on the very edge that raised supply
        if (by_wake) begin
            kick = 1'b1;
            tick(1);
            kick = 1'b0;
        end else begin
            pwr_n = 1'b0;
        end
        wait_sup(1'b1, 40);
        pwr_n = 1'b1;
        n = 0;
        while (pg !== 1'b1 && n < 40) begin
            check("reset held before pgood", prst_n, 0);
            tick(1);
            n++;
        end
        check("pgood delay", n, 8);
        n = 0;
        while (prst_n !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        check("reset release delay", n, 8);
        tick(4);
        check("lamp solid no os", pwl_n, 0);
    endtask : power_up

    task automatic t_reset_button;
        int r0;
        r0 = n_rr;
        press(1);
        check("reset request", n_rr - r0, 1);
        check("supply kept", sup, 1);
    endtask : t_reset_button

    task automatic t_off_os;
        int p0, s0, c0, lit;
        os = 1'b1; s1 = 1'b1; tick(6);
        lit = 0;
        for (int i = 0; i < 16; i++) begin
            lit += int'(pwl_n === 1'b0);
            tick(1);
        end
        check("s1 blink halves", lit, 8);
        s1 = 1'b0; tick(6);
        check("s0 lamp solid", pwl_n, 0);
        p0 = n_pb; s0 = n_smi; c0 = n_sci;
        press(0);
        check("forwarded", n_pb - p0, 1);
        check("sci with os", n_sci - c0, 1);
        check("no smi with os", n_smi - s0, 0);
        check("no status with os", sts, 0);
        tick(60);
        check("no failsafe with os", sup, 1);
        serve = 1'b1; slow = 1'b1;
        press(0);
        wait_sup(1'b0, 60);
        check("off drops all", {pg, prst_n}, 0);
        tick(3);
        check("s5 lamp dark", pwl_n, 1);
        serve = 1'b0; slow = 1'b0; os = 1'b0;
        tick(4);
    endtask : t_off_os

    task automatic t_off_failsafe;
        int s0, c0;
        s0 = n_smi; c0 = n_sci;
        press(0);
        check("smi without os", n_smi - s0, 1);
        check("no sci without os", n_sci - c0, 0);
        check("status set", sts, 1);
        tick(20);
        check("failsafe not early", sup, 1);
        wait_sup(1'b0, 25);
        check("status sticky", sts, 1);
        clr = 1'b1; tick(1); clr = 1'b0; tick(1);
        check("status cleared", sts, 0);
        check("lamp off after failsafe", pwl_n, 1);
    endtask : t_off_failsafe

    // =========================================================
    // Main sequence
    initial begin
        n_mismatch = 0; cmp_count = 0;
        sys_rst = 1'b1; {pwr_n, rbt_n, id_n} = 3'b111;
        {clr, cv, con, serve, slow, kick, os, s1} = 8'h0;
        tick(16);
        sys_rst = 1'b0;
        tick(12);
        t_reset_state();
        t_identify();
        power_up(1'b0);
        t_reset_button();
        t_off_os();
        power_up(1'b1);
        t_off_failsafe();
        finish_test();
    end
endmodule : front_panel_power_control_tb
